// File: testbench/capture_model.sv
// capture-side model: latches buffered words from the port's stream
// assumes stall is driven just after the clock edge
`default_nettype none
module capture_model (
    // clock and stall control
    input  wire logic        i_ref_clk,
    input  wire logic        i_stall,
    // stream from the port
    input  wire logic        i_valid,
    input  wire logic [10:0] i_data,
    output logic             o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] got[$];
    // a stalled capture simply drops ready; no word is taken meanwhile
    assign o_ready = !i_stall;
    always @(posedge i_ref_clk) begin
        if (i_valid && o_ready) got.push_back(i_data);
    end
endmodule
`default_nettype wire

// File: testbench/dual_adc_output_port_control_test.sv
// self-checking bench for the dual converter output port control
// assumes capture_model and the checker are compiled alongside
`default_nettype none
module dual_adc_output_port_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dual_conv_pkg::*;
    localparam int DEPTH = 8;
    logic clk = 1'b0, nrst = 1'b0, ca = 1'b0, cb = 1'b0, sw = 1'b1, stall = 1'b0;
    logic pda = 1'b0, pdb = 1'b0, oela = 1'b0, oelb = 1'b0, ova = 1'b0, ovb = 1'b0;
    logic [1:0]  fmt = 2'h0;
    logic [9:0]  ra = 10'h000, rb = 10'h000, bus_a, bus_b;
    logic        fa, fb, oe_a, oe_b, stab, sv, srdy, sov;
    logic [3:0]  mode_a, mode_b;
    logic [10:0] sd, qa[$], qb[$], exp_s[$];
    logic [31:0] seed = 32'he7899f02;
    int          n_fail = 0, num_checks = 0, fresh = 0, n_ovr = 0;

    dual_conv_port #(.FIFO_DEPTH(DEPTH), .LATENCY(5)) u_dual_conv_port (
        .i_ref_clk(clk), .i_nrst(nrst), .i_sample_clock_a(ca), .i_sample_clock_b(cb),
        .i_bus_swap_select(sw), .i_power_down_select_a(pda), .i_power_down_select_b(pdb),
        .i_output_enable_low_a(oela), .i_output_enable_low_b(oelb), .i_format_level(fmt),
        .i_raw_code_a(ra), .i_raw_over_a(ova), .i_raw_code_b(rb), .i_raw_over_b(ovb),
        .o_result_bus_a(bus_a), .o_range_flag_a(fa), .o_result_oe_a(oe_a),
        .o_result_bus_b(bus_b), .o_range_flag_b(fb), .o_result_oe_b(oe_b),
        .o_stabilizer_on(stab), .o_mode_a(mode_a), .o_mode_b(mode_b), .o_stream_valid(sv),
        .o_stream_data(sd), .i_stream_ready(srdy), .o_stream_overrun(sov));
    capture_model u_capture_model (.i_ref_clk(clk), .i_stall(stall), .i_valid(sv), .i_data(sd), .o_ready(srdy));

    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (sov) n_ovr++;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // word shown after the latest edge: captured five edges earlier
    function automatic logic [10:0] pick(input logic [10:0] q[$]);
        logic [10:0] w;
        w = q[q.size() - 6];
        if (fmt[1]) w[10] = ~w[10];
        return w;
    endfunction
    function automatic logic [3:0] mexp(input logic pd, input logic oel);
        return pd ? (oel ? CH_SLEEP : CH_NAP) : (oel ? CH_HIZ_RUN : CH_NORMAL);
    endfunction
    task automatic cmp(input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check();
        logic ea, eb;
        ea = sw ? !pda && !oela : !pdb && !oelb;
        eb = sw ? !pdb && !oelb : !pda && !oela;
        cmp(11'(oe_a), 11'(ea));
        cmp(11'(oe_b), 11'(eb));
        cmp(11'(mode_a), 11'(mexp(pda, oela)));
        cmp(11'(mode_b), 11'(mexp(pdb, oelb)));
        cmp(11'(stab), 11'(fmt == 2'h1 || fmt == 2'h2));
        if (fresh >= 6 && ea) cmp({bus_a, fa}, sw ? pick(qa) : pick(qb));
        if (fresh >= 6 && eb) cmp({bus_b, fb}, sw ? pick(qb) : pick(qa));
    endtask
    task automatic period(input bit tie, input bit rnd);
        logic [31:0] r;
        r = xs();
        ra = r[9:0];
        ova = r[10];
        rb = r[20:11];
        ovb = r[21];
        if (rnd) begin
            sw = r[22];
            oela = r[23] & r[24];
            oelb = r[25] & r[26];
        end
        @(posedge clk);
        #1;
        ca = 1'b1;
        cb = 1'b1;
        if (tie) sw = 1'b1;
        if (!pda) qa.push_back({ra, ova});
        if (!pdb) qb.push_back({rb, ovb});
        fresh++;
        repeat (3) @(posedge clk);
        #1;
        if (tie) check();
        ca = 1'b0;
        cb = 1'b0;
        if (tie) sw = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check();
    endtask
    task automatic summarize();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #50000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        for (int f = 0; f < 4; f++) begin
            fmt = 2'(f);
            fresh = 0;
            repeat (9) period(1'b0, 1'b1);
        end
        {pda, pdb, oela, oelb} = 4'h0;
        // 15 sleep/sleep, 12 nap/nap, 9 nap/hiz, 6 hiz/nap, 3 hiz/hiz, 0 normal
        for (int m = 15; m >= 0; m -= 3) begin
            {pda, pdb, oela, oelb} = 4'(m);
            repeat (2) period(1'b0, 1'b0);
        end
        repeat (4) period(1'b1, 1'b0);
        sw = 1'b1;
        period(1'b0, 1'b0);
        // the fifo fills while capture stalls, then overflows
        u_capture_model.got.delete();
        stall = 1'b1;
        n_ovr = 0;
        repeat (DEPTH + 4) begin
            period(1'b0, 1'b0);
            exp_s.push_back(pick(qa));
        end
        stall = 1'b0;
        repeat (40) @(posedge clk);
        #1;
        cmp(11'(n_ovr), 11'(4));
        cmp(11'(u_capture_model.got.size()), 11'(DEPTH));
        for (int i = 0; i < DEPTH; i++) cmp(u_capture_model.got[i], exp_s[i]);
        summarize();
    end
endmodule
`default_nettype wire

// File: testbench/dual_conv_port_checker.sv
// port-level assertions for dual_conv_port
// assumes a bind onto the design top and a single clock
`default_nettype none
`include "dual_conv_consts.svh"
module dual_conv_port_checker
    import dual_conv_pkg::*;
(
    // clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_nrst,
    // controls
    input wire logic       i_sample_clock_a,
    input wire logic       i_sample_clock_b,
    input wire logic       i_bus_swap_select,
    input wire logic       i_power_down_select_a,
    input wire logic       i_power_down_select_b,
    input wire logic       i_output_enable_low_a,
    input wire logic       i_output_enable_low_b,
    input wire logic [1:0] i_format_level,
    // results
    input wire logic [9:0] o_result_bus_a,
    input wire logic       o_range_flag_a,
    input wire logic       o_result_oe_a,
    input wire logic [9:0] o_result_bus_b,
    input wire logic       o_range_flag_b,
    input wire logic       o_result_oe_b,
    input wire logic       o_stabilizer_on,
    input wire logic [3:0] o_mode_a,
    input wire logic [3:0] o_mode_b,
    input wire logic       o_stream_overrun
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // properties
    // ----
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    property p_mode_norm; (!i_power_down_select_a && !i_output_enable_low_a) |=> o_mode_a == CH_NORMAL; endproperty
    a_mode_norm: assert property (p_mode_norm) else $error("mode a not normal");
    property p_mode_hiz; (!i_power_down_select_b && i_output_enable_low_b) |=> o_mode_b == CH_HIZ_RUN; endproperty
    a_mode_hiz: assert property (p_mode_hiz) else $error("mode b not hiz-run");
    property p_mode_nap; (i_power_down_select_a && !i_output_enable_low_a) |=> o_mode_a == CH_NAP; endproperty
    a_mode_nap: assert property (p_mode_nap) else $error("mode a not nap");
    property p_mode_sleep; (i_power_down_select_b && i_output_enable_low_b) |=> o_mode_b == CH_SLEEP; endproperty
    a_mode_sleep: assert property (p_mode_sleep) else $error("mode b not sleep");
    // the enable is registered from the unregistered mode decode, so allow three stable cycles
    property p_oe_drive;
        (i_bus_swap_select && !i_power_down_select_a && !i_output_enable_low_a)[*3] |-> o_result_oe_a;
    endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("bus a not driven");
    property p_oe_float; (!i_bus_swap_select && i_output_enable_low_a)[*3] |-> !o_result_oe_b; endproperty
    a_oe_float: assert property (p_oe_float) else $error("bus b driven while disabled");
    property p_reroute;
        (!i_sample_clock_a && !i_sample_clock_b && $stable(i_format_level))[*3] ##0 $changed(i_bus_swap_select)
            |=> {o_result_bus_a, o_range_flag_a} == $past({o_result_bus_b, o_range_flag_b});
    endproperty
    a_reroute: assert property (p_reroute) else $error("swap did not exchange buses");
    property p_stab_on;
        (i_format_level == `CONV_FMT_THIRD || i_format_level == `CONV_FMT_TWO_THIRD) |=> o_stabilizer_on;
    endproperty
    a_stab_on: assert property (p_stab_on) else $error("stabilizer off");
    property p_stab_off;
        (i_format_level == `CONV_FMT_GND || i_format_level == `CONV_FMT_SUPPLY) |=> !o_stabilizer_on;
    endproperty
    a_stab_off: assert property (p_stab_off) else $error("stabilizer on");
    c_overrun: cover property (o_stream_overrun);
    c_sleep: cover property (o_mode_b == CH_SLEEP);
    c_swap: cover property ($changed(i_bus_swap_select) && o_result_oe_a);
endmodule
bind dual_conv_port dual_conv_port_checker u_dual_conv_port_checker (.*);
`default_nettype wire

// File: verilog/conv_channel.sv
// one converter channel: edge-detected sample clock, 5-stage pipeline
// assumes sample clock and raw codes are synchronous to i_ref_clk
`default_nettype none
`include "dual_conv_consts.svh"
module conv_channel
    import dual_conv_pkg::*;
#(
    parameter int LATENCY = `CONV_PIPE_CYCLES
) (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_nrst,
    // control
    input  wire logic       i_sample_clock,
    input  wire logic       i_run,
    // analog result stand-in
    input  wire logic [9:0] i_raw_code,
    input  wire logic       i_raw_over,
    // result
    output logic            o_edge,
    output sample_t         o_result
);
    logic    clk_q;
    sample_t pipe_q [LATENCY];

    // rising edge of the channel's own sample clock starts a sample
    assign o_edge   = i_sample_clock && !clk_q;
    // output appears LATENCY-1 sample edges after capture
    assign o_result = pipe_q[LATENCY-1];

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clk_q <= 1'b0;
        end else begin
            clk_q <= i_sample_clock;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_q[i] <= '0;
            end
        end else if (o_edge && i_run) begin
            pipe_q[0] <= '{word: i_raw_code, range_flag: i_raw_over};
            for (int i = 1; i < LATENCY; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end
endmodule
`default_nettype wire

// File: verilog/dual_conv_consts.svh
// constants for the dual converter output port control
// assumes inclusion by bare name from verilog/ sources
`ifndef DUAL_CONV_CONSTS_SVH
`define DUAL_CONV_CONSTS_SVH
`define CONV_WORD_W        10
`define CONV_PIPE_CYCLES   5
`define CONV_FIFO_DEPTH    8
`define CONV_MSB_POS       9
`define CONV_WORD_RST      10'h000
// format select levels: 0=gnd, 1=1/3 supply, 2=2/3 supply, 3=full supply
`define CONV_FMT_GND       2'h0
`define CONV_FMT_THIRD     2'h1
`define CONV_FMT_TWO_THIRD 2'h2
`define CONV_FMT_SUPPLY    2'h3
`endif

// File: verilog/dual_conv_pkg.sv
// types shared by the dual converter output port control
// assumes the consts header is on the include path
`default_nettype none
package dual_conv_pkg;
    typedef struct packed {
        logic [9:0] word;
        logic       range_flag;
    } sample_t;

    typedef enum logic [3:0] {
        CH_NORMAL   = 4'b0001,
        CH_HIZ_RUN  = 4'b0010,
        CH_NAP      = 4'b0100,
        CH_SLEEP    = 4'b1000
    } chan_mode_t;
endpackage
`default_nettype wire

// File: verilog/dual_conv_port.sv
// output port control of a dual 10-bit sampling converter
// assumes all inputs synchronous to i_ref_clk; bus pins resolved outside
`default_nettype none
`include "dual_conv_consts.svh"

//------------------------------------------------------------
// Function
//------------------------------------------------------------
module dual_conv_port
    import dual_conv_pkg::*;
#(
    parameter int FIFO_DEPTH = `CONV_FIFO_DEPTH,
    parameter int LATENCY    = `CONV_PIPE_CYCLES
) (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_nrst,
    // sample clocks
    input  wire logic       i_sample_clock_a,
    input  wire logic       i_sample_clock_b,
    // channel control
    input  wire logic       i_bus_swap_select,
    input  wire logic       i_power_down_select_a,
    input  wire logic       i_power_down_select_b,
    input  wire logic       i_output_enable_low_a,
    input  wire logic       i_output_enable_low_b,
    input  wire logic [1:0] i_format_level,
    // converted codes from the analog core
    input  wire logic [9:0] i_raw_code_a,
    input  wire logic       i_raw_over_a,
    input  wire logic [9:0] i_raw_code_b,
    input  wire logic       i_raw_over_b,
    // output buses
    output logic [9:0]      o_result_bus_a,
    output logic            o_range_flag_a,
    output logic            o_result_oe_a,
    output logic [9:0]      o_result_bus_b,
    output logic            o_range_flag_b,
    output logic            o_result_oe_b,
    // status
    output logic            o_stabilizer_on,
    output logic [3:0]      o_mode_a,
    output logic [3:0]      o_mode_b,
    // buffered stream of bus a words
    output logic            o_stream_valid,
    output logic [10:0]     o_stream_data,
    input  wire logic       i_stream_ready,
    output logic            o_stream_overrun
);
    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    function automatic chan_mode_t decode_mode(input logic pd, input logic oe_n);
        case ({pd, oe_n})
            2'b00:   decode_mode = CH_NORMAL;
            2'b01:   decode_mode = CH_HIZ_RUN;
            2'b10:   decode_mode = CH_NAP;
            2'b11:   decode_mode = CH_SLEEP;
            default: decode_mode = CH_SLEEP;
        endcase
    endfunction

    // msb flip turns offset binary into two's complement; flag untouched
    function automatic sample_t format_word(input sample_t s, input logic twos);
        format_word = s;
        if (twos) begin
            format_word.word[`CONV_MSB_POS] = ~s.word[`CONV_MSB_POS];
        end
    endfunction

    //------------------------------------------------------------
    // mode decode
    //------------------------------------------------------------
    chan_mode_t mode_a;
    chan_mode_t mode_b;
    logic       twos;
    logic       stab;
    logic       run_a;
    logic       run_b;

    assign mode_a = decode_mode(i_power_down_select_a, i_output_enable_low_a);
    assign mode_b = decode_mode(i_power_down_select_b, i_output_enable_low_b);
    // nap and sleep both halt conversion; hi-z-run keeps the pipeline moving
    assign run_a  = (mode_a == CH_NORMAL) || (mode_a == CH_HIZ_RUN);
    assign run_b  = (mode_b == CH_NORMAL) || (mode_b == CH_HIZ_RUN);

    always_comb begin
        case (i_format_level)
            `CONV_FMT_GND: begin
                twos = 1'b0;
                stab = 1'b0;
            end
            `CONV_FMT_THIRD: begin
                twos = 1'b0;
                stab = 1'b1;
            end
            `CONV_FMT_TWO_THIRD: begin
                twos = 1'b1;
                stab = 1'b1;
            end
            default: begin
                twos = 1'b1;
                stab = 1'b0;
            end
        endcase
    end

    //------------------------------------------------------------
    // channels
    //------------------------------------------------------------
    sample_t res_a;
    sample_t res_b;
    logic    edge_a;
    logic    edge_b;

    conv_channel #(.LATENCY(LATENCY)) u_chan_a (
        .i_ref_clk      (i_ref_clk),
        .i_nrst         (i_nrst),
        .i_sample_clock (i_sample_clock_a),
        .i_run          (run_a),
        .i_raw_code     (i_raw_code_a),
        .i_raw_over     (i_raw_over_a),
        .o_edge         (edge_a),
        .o_result       (res_a)
    );

    conv_channel #(.LATENCY(LATENCY)) u_chan_b (
        .i_ref_clk      (i_ref_clk),
        .i_nrst         (i_nrst),
        .i_sample_clock (i_sample_clock_b),
        .i_run          (run_b),
        .i_raw_code     (i_raw_code_b),
        .i_raw_over     (i_raw_over_b),
        .o_edge         (edge_b),
        .o_result       (res_b)
    );

    //------------------------------------------------------------
    // bus routing
    //------------------------------------------------------------
    // interleaving on one bus works only if swap and both sample clocks
    // are one common signal outside
    sample_t shown_a_q;
    sample_t shown_b_q;
    sample_t cur_a;
    sample_t cur_b;
    logic    take_a;
    logic    take_b;
    sample_t bus_a_d;
    sample_t bus_b_d;
    logic    upd_a;

    // a napping or sleeping channel still sees edges but must not advance
    assign take_a = edge_a && run_a;
    assign take_b = edge_b && run_b;

    // each channel keeps the word it presents now, so a swap change
    // reroutes that word and not the next one waiting in the pipeline
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            shown_a_q <= '0;
        end else if (take_a) begin
            shown_a_q <= res_a;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            shown_b_q <= '0;
        end else if (take_b) begin
            shown_b_q <= res_b;
        end
    end

    assign cur_a = take_a ? res_a : shown_a_q;
    assign cur_b = take_b ? res_b : shown_b_q;

    always_comb begin
        if (i_bus_swap_select) begin
            bus_a_d = format_word(cur_a, twos);
            bus_b_d = format_word(cur_b, twos);
            upd_a   = take_a;
        end else begin
            bus_a_d = format_word(cur_b, twos);
            bus_b_d = format_word(cur_a, twos);
            upd_a   = take_b;
        end
    end

    // data and flag are refreshed together from one struct
    sample_t bus_a_q;
    sample_t bus_b_q;

    // refreshed every cycle, so a swap or format change shows on the next clock
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_a_q <= '0;
            bus_b_q <= '0;
        end else begin
            bus_a_q <= bus_a_d;
            bus_b_q <= bus_b_d;
        end
    end

    assign o_result_bus_a = bus_a_q.word;
    assign o_range_flag_a = bus_a_q.range_flag;
    assign o_result_bus_b = bus_b_q.word;
    assign o_range_flag_b = bus_b_q.range_flag;

    //------------------------------------------------------------
    // output enables and status
    //------------------------------------------------------------
    // the bus follows the enable of the channel whose data it carries
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_result_oe_a <= 1'b0;
            o_result_oe_b <= 1'b0;
        end else begin
            o_result_oe_a <= i_bus_swap_select ? (mode_a == CH_NORMAL) : (mode_b == CH_NORMAL);
            o_result_oe_b <= i_bus_swap_select ? (mode_b == CH_NORMAL) : (mode_a == CH_NORMAL);
        end
    end

    // status mirrors the decoded pins one cycle late
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_stabilizer_on <= 1'b0;
            o_mode_a        <= 4'h0;
            o_mode_b        <= 4'h0;
        end else begin
            o_stabilizer_on <= stab;
            o_mode_a        <= mode_a;
            o_mode_b        <= mode_b;
        end
    end

    //------------------------------------------------------------
    // stream buffer of bus a words
    //------------------------------------------------------------
    // a full buffer drops the word and flags it: the converter cannot stall
    logic       push_v;
    logic       fifo_in_ready;
    logic       f_valid;
    logic [10:0] f_data;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            push_v <= 1'b0;
        end else begin
            push_v <= upd_a && o_result_oe_a;
        end
    end

    sample_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (push_v),
        .i_in_data   (bus_a_q),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (f_valid),
        .o_out_data  (f_data),
        .i_out_ready (i_stream_ready && !o_stream_valid)
    );

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_stream_valid <= 1'b0;
            o_stream_data  <= 11'h000;
        end else begin
            if (f_valid && i_stream_ready && !o_stream_valid) begin
                o_stream_valid <= 1'b1;
                o_stream_data  <= f_data;
            end else begin
                o_stream_valid <= 1'b0;
            end
        end
    end

    // one pulse per dropped word, so the far side can count its losses
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_stream_overrun <= 1'b0;
        end else begin
            o_stream_overrun <= push_v && !fifo_in_ready;
        end
    end
endmodule
`default_nettype wire

// File: verilog/sample_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes a single clock and active-low async reset
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    // fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire
